// ### common/bpf_pkg.sv
package bpf_pkg;

  // ************************************************************
  // eligibility profiles, opcode classes and operand forms
  // ************************************************************
  typedef enum logic [1:0]
  {
    BPF_GEN1 = 2'h0,
    BPF_GEN2 = 2'h1,
    BPF_GEN3 = 2'h2,
    BPF_GEN4 = 2'h3
  } bpf_gen_t;

  typedef enum logic [2:0]
  {
    CLS_OTHER = 3'h0,
    CLS_CMP   = 3'h1,
    CLS_TEST  = 3'h2,
    CLS_AND   = 3'h3,
    CLS_ADD   = 3'h4,
    CLS_SUB   = 3'h5,
    CLS_INC   = 3'h6,
    CLS_DEC   = 3'h7
  } bpf_cls_t;

  typedef enum logic [2:0]
  {
    FORM_NONE = 3'h0,
    FORM_RR   = 3'h1,
    FORM_RI   = 3'h2,
    FORM_RM   = 3'h3,
    FORM_MR   = 3'h4,
    FORM_MI   = 3'h5
  } bpf_form_t;

  // ************************************************************
  // bundle geometry
  // ************************************************************
  localparam int BPF_SLOTS = 5;
  localparam int BPF_UOPS  = 4;
  localparam int BPF_PAIRS = 4;

  // ************************************************************
  // conditional jump opcodes
  // ************************************************************
  localparam logic [7:0] JCC_SHORT_LO = 8'h70;
  localparam logic [7:0] JCC_SHORT_HI = 8'h7f;
  localparam logic [7:0] JCC_ESCAPE   = 8'h0f;
  localparam logic [7:0] JCC_NEAR_LO  = 8'h80;
  localparam logic [7:0] JCC_NEAR_HI  = 8'h8f;

  // ************************************************************
  // condition masks, one bit per condition nibble
  // ************************************************************
  localparam logic [15:0] COND_ALL    = 16'hffff;
  localparam logic [15:0] COND_CZ     = 16'h00fc;  // nibbles 2..7
  localparam logic [15:0] COND_SIGNED = 16'hf000;  // nibbles c..f
  localparam logic [15:0] COND_EQNE   = 16'h0030;  // nibbles 4,5

  // ************************************************************
  // micro-op costs
  // ************************************************************
  localparam logic [4:0] MP_PENALTY_BASE  = 5'h10;
  localparam logic [4:0] MP_FUSED_SAVING  = 5'h01;
  localparam logic [1:0] UOP_SLOT_COST    = 2'h1;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed
  {
    logic      vld;
    bpf_cls_t  cls;
    bpf_form_t form;
    logic      mfused;
    logic [7:0] op0;
    logic [7:0] op1;
    logic [7:0] tag;
  } bpf_insn_t;

  typedef struct packed
  {
    logic       vld;
    logic       fused;
    logic       is_br;
    bpf_cls_t   cls;
    bpf_form_t  form;
    logic       mfused;
    logic [7:0] op0;
    logic [7:0] op1;
    logic [3:0] cond;
    logic [7:0] tag;
    logic [7:0] br_tag;
    logic [4:0] mp_penalty;
    logic [1:0] slot_cost;
  } bpf_uop_t;

endpackage

// ### rtl/bpf_elig.sv
module bpf_elig
  import bpf_pkg::*;
#(
  parameter bpf_gen_t GEN = BPF_GEN4
)
(
  input  wire logic      mode64,
  input  wire bpf_insn_t first,
  input  wire logic      br_vld,
  input  wire logic      br_is_jcc,
  input  wire logic [3:0] br_cond,
  output logic           ok
);

  // ************************************************************
  // condition mask per profile and class
  // ************************************************************
  function automatic logic [15:0] cond_mask(input bpf_gen_t g, input bpf_cls_t c);
    logic [15:0] m;
    m = 16'h0000;
    if (c == CLS_TEST)
      m = COND_ALL;
    else if (g == BPF_GEN1 && c == CLS_CMP)
      m = COND_CZ;
    else if (g == BPF_GEN2 && c == CLS_CMP)
      m = COND_CZ | COND_SIGNED;
    else if (g == BPF_GEN3 || g == BPF_GEN4)
    begin
      case (c)
        CLS_AND:                   m = COND_ALL;
        CLS_CMP, CLS_ADD, CLS_SUB: m = COND_CZ | COND_SIGNED;
        CLS_INC, CLS_DEC:          m = COND_EQNE | COND_SIGNED;
        default:                   m = 16'h0000;
      endcase
    end
    return m;
  endfunction

  // ************************************************************
  // operand form, mode and condition checks
  // ************************************************************
  logic cmp_test;
  logic form_ok;
  logic mode_ok;
  logic cond_ok;
  logic [15:0] cond_set;

  assign cmp_test = (first.cls == CLS_CMP) || (first.cls == CLS_TEST);
  // memory-immediate never fuses; a load-op form needs its own fusion
  assign form_ok  = (first.form == FORM_RR) || (first.form == FORM_RI)
                    || ((first.form == FORM_RM) && first.mfused)
                    || ((first.form == FORM_MR)
                        && (cmp_test || GEN == BPF_GEN3));
  // 64-bit mode only blocks the first profile
  assign mode_ok  = !(GEN == BPF_GEN1 && mode64);
  // a function result cannot be bit-selected directly, so it lands on a wire first
  assign cond_set = cond_mask(GEN, first.cls);
  assign cond_ok  = cond_set[br_cond];
  assign ok       = first.vld && br_vld && br_is_jcc
                    && form_ok && mode_ok && cond_ok;

endmodule

// ### rtl/bpf_fuse_decode.sv
module bpf_fuse_decode
  import bpf_pkg::*;
#(
  parameter bpf_gen_t GEN = BPF_GEN4
)
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       mode64,
  input  wire logic                       in_valid,
  input  wire bpf_insn_t [BPF_SLOTS-1:0]  in_bundle,
  output logic                            in_ready,
  input  wire logic                       out_ready,
  output logic                            out_valid,
  output bpf_uop_t [BPF_UOPS-1:0]         out_uops
);

  // ************************************************************
  // state and registers
  // ************************************************************
  typedef enum logic
  {
    ST_OPEN  = 1'b0,
    ST_DRAIN = 1'b1
  } bpf_state_t;

  bpf_state_t                     state_q;
  bpf_state_t                     state_d;
  bpf_insn_t [BPF_SLOTS-1:0]      bundle_q;
  bpf_insn_t [BPF_SLOTS-1:0]      bundle_d;
  bpf_uop_t [BPF_UOPS-1:0]        uops_q;
  bpf_uop_t [BPF_UOPS-1:0]        uops_d;
  logic                           out_valid_q;
  logic                           out_valid_d;
  logic                           in_ready_q;
  logic                           in_ready_d;

  // ************************************************************
  // source selection
  // ************************************************************
  bpf_insn_t [BPF_SLOTS-1:0]      src;
  logic                           take_in;
  logic                           adv;
  logic                           src_any;

  // a fresh bundle is only taken while nothing is left over from the last one
  assign take_in = in_valid && in_ready_q;
  // the output register may be refilled when empty or when it is drained
  assign adv     = !out_valid_q || out_ready;
  assign src     = (state_q == ST_OPEN) ? (take_in ? in_bundle : '0) : bundle_q;
  assign src_any = src[0].vld;

  // ************************************************************
  // per-slot jump recognition and per-pair eligibility
  // ************************************************************
  logic [BPF_SLOTS-1:0]           is_jcc;
  logic [3:0]                     cond [BPF_SLOTS];
  logic [BPF_PAIRS-1:0]           pair_ok;

  for (genvar s = 0; s < BPF_SLOTS; s++)
  begin : g_jcc
    bpf_jcc_dec u_jcc
    (
      .op0    (src[s].op0),
      .op1    (src[s].op1),
      .is_jcc (is_jcc[s]),
      .cond   (cond[s])
    );
  end

  for (genvar p = 0; p < BPF_PAIRS; p++)
  begin : g_pair
    bpf_elig #(.GEN(GEN)) u_elig
    (
      .mode64    (mode64),
      .first     (src[p]),
      .br_vld    (src[p+1].vld),
      .br_is_jcc (is_jcc[p+1]),
      .br_cond   (cond[p+1]),
      .ok        (pair_ok[p])
    );
  end

  // ************************************************************
  // micro-op builders
  // ************************************************************
  // an unfused instruction passes through untouched so results cannot differ
  function automatic bpf_uop_t mk_single(input bpf_insn_t i, input logic br,
                                         input logic [3:0] c);
    bpf_uop_t u;
    u            = '0;
    u.vld        = 1'b1;
    u.is_br      = br;
    u.cls        = i.cls;
    u.form       = i.form;
    u.mfused     = i.mfused;
    u.op0        = i.op0;
    u.op1        = i.op1;
    u.cond       = br ? c : 4'h0;
    u.tag        = i.tag;
    u.br_tag     = br ? i.tag : 8'h00;
    u.mp_penalty = br ? MP_PENALTY_BASE : 5'h00;
    u.slot_cost  = UOP_SLOT_COST;
    return u;
  endfunction

  // the pair carries the flag-setter's operands and the jump's condition
  function automatic bpf_uop_t mk_fused(input bpf_insn_t a, input bpf_insn_t b,
                                        input logic [3:0] c);
    bpf_uop_t u;
    u            = '0;
    u.vld        = 1'b1;
    u.fused      = 1'b1;
    u.is_br      = 1'b1;
    u.cls        = a.cls;
    u.form       = a.form;
    u.mfused     = a.mfused;
    u.op0        = a.op0;
    u.op1        = a.op1;
    u.cond       = c;
    u.tag        = a.tag;
    u.br_tag     = b.tag;
    u.mp_penalty = MP_PENALTY_BASE - MP_FUSED_SAVING;
    u.slot_cost  = UOP_SLOT_COST;
    return u;
  endfunction

  // ************************************************************
  // walk the source in program order
  // ************************************************************
  bpf_uop_t [BPF_UOPS-1:0]        walk_uops;
  bpf_insn_t [BPF_SLOTS-1:0]      walk_rest;

  // four output lanes with one fused pair allowed keeps decode at five per cycle
  always_comb
  begin
    int  pos;
    logic used;
    pos       = 0;
    used      = 1'b0;
    walk_uops = '0;
    walk_rest = '0;
    for (int k = 0; k < BPF_UOPS; k++)
    begin
      if (pos < BPF_SLOTS)
      begin
        if (src[pos].vld)
        begin
          if (!used && pos < BPF_PAIRS && pair_ok[pos])
          begin
            walk_uops[k] = mk_fused(src[pos], src[pos+1], cond[pos+1]);
            used         = 1'b1;
            pos          = pos + 2;
          end
          else
          begin
            walk_uops[k] = mk_single(src[pos], is_jcc[pos], cond[pos]);
            pos          = pos + 1;
          end
        end
      end
    end
    // left-over instructions move to the head and wait for the next cycle
    for (int j = 0; j < BPF_SLOTS; j++)
    begin
      if (j + pos < BPF_SLOTS)
      begin
        walk_rest[j] = src[j+pos];
      end
    end
  end

  // ************************************************************
  // next-state selection
  // ************************************************************
  logic rest_any;

  assign bundle_d    = adv ? walk_rest : src;
  assign rest_any    = bundle_d[0].vld;
  assign state_d     = rest_any ? ST_DRAIN : ST_OPEN;
  // ready is promised one cycle ahead so it can come from a flop
  assign in_ready_d  = !rest_any;
  assign out_valid_d = adv ? src_any : out_valid_q;
  assign uops_d      = adv ? walk_uops : uops_q;

  // ************************************************************
  // registers
  // ************************************************************
  // state and ready flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q    <= ST_OPEN;
      in_ready_q <= 1'b1;
    end
    else
    begin
      state_q    <= state_d;
      in_ready_q <= in_ready_d;
    end
  end

  // held instructions and output micro-ops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bundle_q    <= '0;
      uops_q      <= '0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      bundle_q    <= bundle_d;
      uops_q      <= uops_d;
      out_valid_q <= out_valid_d;
    end
  end

  assign in_ready  = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_uops  = uops_q;

endmodule

// ### rtl/bpf_jcc_dec.sv
module bpf_jcc_dec
  import bpf_pkg::*;
(
  input  wire logic [7:0] op0,
  input  wire logic [7:0] op1,
  output logic            is_jcc,
  output logic [3:0]      cond
);

  // ************************************************************
  // short and near conditional jump forms
  // ************************************************************
  logic short_hit;
  logic near_hit;

  // condition is always the low nibble of the last opcode byte
  assign short_hit = (op0 >= JCC_SHORT_LO) && (op0 <= JCC_SHORT_HI);
  assign near_hit  = (op0 == JCC_ESCAPE) && (op1 >= JCC_NEAR_LO)
                     && (op1 <= JCC_NEAR_HI);
  assign is_jcc    = short_hit | near_hit;
  assign cond      = short_hit ? op0[3:0] : op1[3:0];

endmodule

// ### sim/bpf_fuse_props.sv
module bpf_fuse_props
  import bpf_pkg::*;
#(
  parameter bpf_gen_t GEN = BPF_GEN4
)
(
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic                      mode64,
  input wire logic                      in_valid,
  input wire bpf_insn_t [BPF_SLOTS-1:0] in_bundle,
  input wire logic                      in_ready,
  input wire logic                      out_ready,
  input wire logic                      out_valid,
  input wire bpf_uop_t [BPF_UOPS-1:0]   out_uops
);
  // ************************************************************
  // helpers
  // ************************************************************
  localparam logic [15:0] INCDEC_OK = COND_EQNE | COND_SIGNED;
  wire bpf_uop_t   u0;
  wire logic [2:0] n_fused;
  // lane 0 is the oldest and carries most pairs, so it is watched closely
  assign u0 = out_uops[0];
  // a second fused lane would mean two pairs in one cycle
  assign n_fused = 3'(out_uops[0].fused) + 3'(out_uops[1].fused)
                 + 3'(out_uops[2].fused) + 3'(out_uops[3].fused);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ************************************************************
  // properties
  // ************************************************************
  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  sequence s_take;
    in_valid && in_ready && in_bundle[0].vld && (!out_valid || out_ready);
  endsequence
  sequence s_pair;
    out_valid && u0.fused;
  endsequence
  property p_hold;
    s_stall |=> out_valid && $stable(out_uops);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while stalled");
  property p_answer;
    s_take |=> out_valid && out_uops[0].vld;
  endproperty
  a_answer: assert property (p_answer) else $error("taken bundle not answered");
  property p_one_pair;
    out_valid |-> n_fused <= 3'h1;
  endproperty
  a_one_pair: assert property (p_one_pair) else $error("two pairs in one cycle");
  property p_cost;
    s_pair |-> u0.is_br && u0.slot_cost == UOP_SLOT_COST;
  endproperty
  a_cost: assert property (p_cost) else $error("pair slot cost wrong");
  property p_pen;
    s_pair |-> u0.mp_penalty == MP_PENALTY_BASE - MP_FUSED_SAVING;
  endproperty
  a_pen: assert property (p_pen) else $error("pair penalty wrong");
  property p_no_mi;
    s_pair |-> u0.form != FORM_MI;
  endproperty
  a_no_mi: assert property (p_no_mi) else $error("mem-imm pair fused");
  property p_rm;
    s_pair ##0 (u0.form == FORM_RM) |-> u0.mfused;
  endproperty
  a_rm: assert property (p_rm) else $error("unfused rm form paired");
  property p_gen1;
    s_pair ##0 (GEN == BPF_GEN1)
      |-> u0.cls == CLS_TEST || (u0.cls == CLS_CMP && COND_CZ[u0.cond]);
  endproperty
  a_gen1: assert property (p_gen1) else $error("first profile pair not allowed");
  property p_incdec;
    s_pair ##0 (GEN == BPF_GEN4 && u0.cls inside {CLS_INC, CLS_DEC}) |-> INCDEC_OK[u0.cond];
  endproperty
  a_incdec: assert property (p_incdec) else $error("inc/dec pair condition");
endmodule

bind bpf_fuse_decode bpf_fuse_props #(.GEN(GEN)) i_props (.clk(clk), .nrst(nrst),
  .mode64(mode64), .in_valid(in_valid), .in_bundle(in_bundle), .in_ready(in_ready),
  .out_ready(out_ready), .out_valid(out_valid), .out_uops(out_uops));

// ### sim/bpf_sink_model.sv
module bpf_sink_model
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic stall,
  output logic     out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // dispatch side: ready follows the stall command one edge late, like a queue filling
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      out_ready <= 1'b0;
    else
      out_ready <= !stall;
  end
endmodule

// ### sim/tb_bpf_fuse_decode.sv
module tb_bpf_fuse_decode;
  import bpf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    bpf_cls_t cls; bpf_form_t form; logic mf; logic [7:0] j0; logic [7:0] j1;
    logic m64; logic [3:0] fz;
  } bpf_row_t;
  logic                      clk = 1'b0, nrst = 1'b0, mode64 = 1'b0, in_valid = 1'b0;
  logic                      stall = 1'b0;
  bpf_insn_t [BPF_SLOTS-1:0] in_bundle = '0;
  logic                      out_ready, rdy_a, rdy_b, rdy_c, rdy_d, ov_a, ov_b, ov_c, ov_d;
  bpf_uop_t [BPF_UOPS-1:0]   uo_a, uo_b, uo_c, uo_d;
  int                        miscompares = 0, samples_checked = 0;
  // ************************************************************
  // table of pairs: first insn class/form, jump bytes, mode, fuse per profile (bit 0 = first)
  // ************************************************************
  bpf_row_t rows [0:16] = '{
    '{CLS_CMP, FORM_RI, 1'b0, 8'h73, 8'h00, 1'b0, 4'hf},
    '{CLS_CMP, FORM_MI, 1'b0, 8'h0f, 8'h8d, 1'b0, 4'h0},
    '{CLS_CMP, FORM_RR, 1'b0, 8'h7c, 8'h00, 1'b0, 4'he},
    '{CLS_CMP, FORM_RR, 1'b0, 8'h77, 8'h00, 1'b0, 4'hf},
    '{CLS_TEST, FORM_RR, 1'b0, 8'h70, 8'h00, 1'b0, 4'hf},
    '{CLS_CMP, FORM_RI, 1'b0, 8'h73, 8'h00, 1'b1, 4'he},
    '{CLS_CMP, FORM_RM, 1'b0, 8'h74, 8'h00, 1'b0, 4'h0},
    '{CLS_CMP, FORM_RM, 1'b1, 8'h74, 8'h00, 1'b0, 4'hf},
    '{CLS_CMP, FORM_MR, 1'b0, 8'h75, 8'h00, 1'b0, 4'hf},
    '{CLS_INC, FORM_RR, 1'b0, 8'h72, 8'h00, 1'b0, 4'h0},
    '{CLS_DEC, FORM_RR, 1'b0, 8'h0f, 8'h84, 1'b0, 4'hc},
    '{CLS_ADD, FORM_RI, 1'b0, 8'h70, 8'h00, 1'b0, 4'h0},
    '{CLS_SUB, FORM_RR, 1'b0, 8'h7e, 8'h00, 1'b0, 4'hc},
    '{CLS_AND, FORM_RR, 1'b0, 8'h7a, 8'h00, 1'b0, 4'hc},
    '{CLS_CMP, FORM_RR, 1'b0, 8'h0f, 8'h90, 1'b0, 4'h0},
    '{CLS_TEST, FORM_MI, 1'b0, 8'h75, 8'h00, 1'b0, 4'h0},
    '{CLS_ADD, FORM_MR, 1'b0, 8'h75, 8'h00, 1'b0, 4'h4}
  };
  always #5 clk = ~clk;
  // ************************************************************
  // four profiles side by side, same stream, same dispatch side
  // ************************************************************
  bpf_fuse_decode #(.GEN(BPF_GEN4)) i_dut (.clk(clk), .nrst(nrst), .mode64(mode64),
    .in_valid(in_valid), .in_bundle(in_bundle), .in_ready(rdy_a), .out_ready(out_ready),
    .out_valid(ov_a), .out_uops(uo_a));
  bpf_fuse_decode #(.GEN(BPF_GEN1)) i_dut_g1 (.clk(clk), .nrst(nrst), .mode64(mode64),
    .in_valid(in_valid), .in_bundle(in_bundle), .in_ready(rdy_b), .out_ready(out_ready),
    .out_valid(ov_b), .out_uops(uo_b));
  bpf_fuse_decode #(.GEN(BPF_GEN2)) i_dut_g2 (.clk(clk), .nrst(nrst), .mode64(mode64),
    .in_valid(in_valid), .in_bundle(in_bundle), .in_ready(rdy_c), .out_ready(out_ready),
    .out_valid(ov_c), .out_uops(uo_c));
  bpf_fuse_decode #(.GEN(BPF_GEN3)) i_dut_g3 (.clk(clk), .nrst(nrst), .mode64(mode64),
    .in_valid(in_valid), .in_bundle(in_bundle), .in_ready(rdy_d), .out_ready(out_ready),
    .out_valid(ov_d), .out_uops(uo_d));
  bpf_sink_model i_sink (.clk(clk), .nrst(nrst), .stall(stall), .out_ready(out_ready));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic summarize;
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stuck;
    miscompares++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic bpf_insn_t mk(bpf_cls_t c, bpf_form_t f, logic m, logic [7:0] a,
                                   logic [7:0] b, logic [7:0] t);
    return '{1'b1, c, f, m, a, b, t};
  endfunction
  // holds the bundle until all four decoders are ready, polled between edges
  task automatic send(input bpf_insn_t [BPF_SLOTS-1:0] b, input logic m);
    int n;
    @(posedge clk);
    in_bundle <= b;
    mode64    <= m;
    in_valid  <= 1'b1;
    @(negedge clk);
    for (n = 0; n < 50 && (rdy_a & rdy_b & rdy_c & rdy_d) !== 1'b1; n++)
      @(negedge clk);
    if (n == 50)
      stuck();
    @(posedge clk);
    in_valid <= 1'b0;
  endtask
  task automatic wait_out;
    int n;
    @(negedge clk);
    for (n = 0; n < 50 && ov_a !== 1'b1; n++)
      @(negedge clk);
    if (n == 50)
      stuck();
  endtask
  // a split pair must come out as two untouched micro-ops
  task automatic chk_row(input bpf_uop_t [BPF_UOPS-1:0] u, input logic f, input bpf_row_t r,
                         input logic [7:0] t);
    logic esc, isj;
    esc = r.j0 == JCC_ESCAPE;
    isj = esc ? r.j1[7:4] == 4'h8 : r.j0[7:4] == 4'h7;
    chk(u[0].fused, f);
    chk(u[0].tag, t);
    chk({u[0].cls, u[0].form, u[0].op0, u[0].op1}, {r.cls, r.form, 16'h3bc1});
    if (f)
    begin
      chk(u[0].cond, esc ? r.j1[3:0] : r.j0[3:0]);
      chk({u[0].is_br, u[0].mp_penalty}, {1'b1, MP_PENALTY_BASE - MP_FUSED_SAVING});
      chk(u[0].br_tag, t + 8'h40);
      chk(u[1].vld, 1'b0);
    end
    else
    begin
      chk(u[1].tag, t + 8'h40);
      chk({u[1].op0, u[1].op1, u[1].is_br}, {r.j0, r.j1, isj});
      chk(u[1].mp_penalty, isj ? MP_PENALTY_BASE : 5'h00);
    end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    bpf_insn_t [BPF_SLOTS-1:0] b;
    int i;
    repeat (5) @(posedge clk);
    chk({rdy_a, ov_a}, 2'h2);
    nrst <= 1'b1;
    for (i = 0; i < 17; i++)
    begin
      b    = '0;
      b[0] = mk(rows[i].cls, rows[i].form, rows[i].mf, 8'h3b, 8'hc1, 8'(i));
      b[1] = mk(CLS_OTHER, FORM_NONE, 1'b0, rows[i].j0, rows[i].j1, 8'(i) + 8'h40);
      send(b, rows[i].m64);
      wait_out();
      chk({ov_d, ov_c, ov_b, ov_a}, 4'hf);
      chk_row(uo_a, rows[i].fz[3], rows[i], 8'(i));
      chk_row(uo_b, rows[i].fz[0], rows[i], 8'(i));
      chk_row(uo_c, rows[i].fz[1], rows[i], 8'(i));
      chk_row(uo_d, rows[i].fz[2], rows[i], 8'(i));
    end
    // full width: one pair plus three plain instructions in one output
    b = {mk(CLS_INC, FORM_RR, 1'b0, 8'h01, 8'h02, 8'h05),
         mk(CLS_SUB, FORM_RR, 1'b0, 8'h01, 8'h02, 8'h04),
         mk(CLS_ADD, FORM_RR, 1'b0, 8'h01, 8'h02, 8'h03),
         mk(CLS_OTHER, FORM_NONE, 1'b0, 8'h73, 8'h00, 8'h02),
         mk(CLS_CMP, FORM_RI, 1'b0, 8'h3b, 8'hc1, 8'h01)};
    send(b, 1'b0);
    wait_out();
    chk({uo_a[0].fused, uo_a[0].br_tag, uo_a[3].tag}, {1'b1, 8'h02, 8'h05});
    chk({uo_a[1].tag, uo_a[2].tag, uo_a[0].slot_cost}, {8'h03, 8'h04, 2'h1});
    // five plain instructions under a stall: four lanes, one left over
    stall <= 1'b1;
    for (i = 0; i < 5; i++)
      b[i] = mk(CLS_ADD, FORM_RR, 1'b0, 8'h01, 8'h02, 8'h11 + 8'(i));
    send(b, 1'b0);
    repeat (4) @(negedge clk);
    chk({ov_a, rdy_a, uo_a[0].tag, uo_a[3].tag}, {2'h2, 8'h11, 8'h14});
    stall <= 1'b0;
    for (i = 0; i < 50 && uo_a[0].tag !== 8'h15; i++)
      @(negedge clk);
    chk({uo_a[0].tag, uo_a[1].vld, uo_a[0].fused}, {8'h15, 2'h0});
    // reset in mid-run drops the output, then a plain pair must still fuse
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    chk({rdy_a, ov_a, uo_a[0].vld}, 3'h4);
    nrst <= 1'b1;
    b    = '0;
    b[0] = mk(CLS_CMP, FORM_RI, 1'b0, 8'h3b, 8'hc1, 8'h20);
    b[1] = mk(CLS_OTHER, FORM_NONE, 1'b0, 8'h73, 8'h00, 8'h60);
    send(b, 1'b0);
    wait_out();
    chk_row(uo_a, 1'b1, rows[0], 8'h20);
    summarize();
  end
endmodule
